// [hw/gcc_config_comp.sv]
// gauge configuration decode and compensation
// assumes gauge measurements are synchronous and nv image stable at reset
`timescale 1ns/1ps
module gcc_config_comp #(
	parameter longint SI_PERIOD_CYC = gcc_pkg::SI_PERIOD_CYC,
	parameter longint SD_UNIT_CYC = gcc_pkg::SD_UNIT_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// nonvolatile image, taken at reset
	input wire gcc_pkg::gcc_cfg_t i_nv,
	// configuration access
	input wire logic i_cfg_wr,
	input wire logic i_update_pack_config_cmd,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	output logic [7:0] o_cfg_rdata,
	// mode register pin enable access
	input wire logic i_gp_en_wr,
	input wire logic i_gp_en_wdata,
	// other programmed bytes
	input wire logic [7:0] i_discharge_comp_byte,
	input wire logic [7:0] i_temp_comp_byte,
	// gauge state
	input wire gcc_pkg::gcc_meas_t i_meas,
	input wire logic signed [7:0] i_internal_offset,
	input wire logic i_charged_full,
	input wire logic i_cycles_since_learning_inc,
	// general purpose pin
	input wire logic i_gp_i,
	output logic o_gp_o,
	output logic o_gp_oe,
	output logic o_gp_pin_input_enable,
	output logic o_gp_pin_status,
	// standby and filter
	output logic [15:0] o_standby_current,
	output logic [3:0] o_activity_filter_threshold,
	output logic o_learn_disqualified,
	// self-discharge and aging
	output logic o_nac_reduce,
	output logic [15:0] o_nac_reduce_amt,
	output logic o_lmd_reduce,
	output logic [15:0] o_lmd_reduce_amt,
	// charge termination
	output logic [6:0] o_taper_threshold,
	output logic [15:0] o_term_voltage_mv,
	output logic o_full_charge,
	// compensation
	output logic signed [7:0] o_offset_total,
	output logic [7:0] o_eff_discharge_comp,
	output logic [7:0] o_eff_temp_comp,
	output logic [23:0] o_aged_discharge_gain,
	output logic [15:0] o_compensated_edv,
	output logic [15:0] o_first_empty_eff
);
	gcc_pkg::gcc_cfg_t cfg_ff;
	logic gp_en_ff;
	logic [15:0] si_ff;
	logic [2:0] sd_cnt_ff;
	logic cycles_since_learning_odd_ff;

	// field views
	logic [2:0] initial_standby_current;
	logic [3:0] edv_temp_coefficient;
	logic [3:0] activity_filter_threshold;
	logic [3:0] self_discharge_rate;
	logic aging_en;
	logic [1:0] age_factor;
	logic [5:0] edv_rate_gain;
	logic [7:0] eff_discharge_comp_byte;
	logic [7:0] eff_temp_comp_byte;
	logic [4:0] discharge_gain;
	logic [4:0] temperature_gain;
	logic signed [8:0] toff_c;
	logic [8:0] deficit;
	logic cold;

	assign initial_standby_current = cfg_ff.standby_init_edv_temp_cfg[gcc_pkg::INITIAL_STANDBY_CURRENT_LSB +: 3];
	assign edv_temp_coefficient = cfg_ff.standby_init_edv_temp_cfg[3:0];
	assign activity_filter_threshold = cfg_ff.filter_selfdischarge_cfg[gcc_pkg::DMF_LSB +: 4];
	assign self_discharge_rate = cfg_ff.filter_selfdischarge_cfg[3:0];
	assign aging_en = cfg_ff.aging_fullcharge_current_cfg[gcc_pkg::AGING_EN_BIT];
	assign age_factor = cfg_ff.age_gain_edv_rate_cfg[gcc_pkg::GAF_LSB +: 2];
	assign edv_rate_gain = cfg_ff.age_gain_edv_rate_cfg[5:0];
	assign eff_discharge_comp_byte = cfg_ff.pack_options_cfg[gcc_pkg::FIXED_DISCHARGE_COMP_BIT] ?
		gcc_pkg::FIXED_DISCHARGE_COMP : i_discharge_comp_byte;
	assign eff_temp_comp_byte = cfg_ff.pack_options_cfg[gcc_pkg::FIXED_TEMP_COMP_BIT] ?
		gcc_pkg::FIXED_TEMP_COMP : i_temp_comp_byte;
	assign discharge_gain = eff_discharge_comp_byte[7:3];
	assign temperature_gain = eff_temp_comp_byte[7:3];
	assign toff_c = $signed({5'h0, eff_temp_comp_byte[2:0], 1'b0});
	assign cold = $signed({i_meas.temp_c[7], i_meas.temp_c}) < toff_c;
	assign deficit = cold ? 9'(toff_c - $signed({i_meas.temp_c[7], i_meas.temp_c})) : 9'h0;

	// configuration shadow, reloaded from the nv image on reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cfg_ff <= i_nv;
		end else if (i_cfg_wr || i_update_pack_config_cmd) begin
			case (i_cfg_addr)
				gcc_pkg::ADDR_STANDBY_EDV_TEMP_COEFFICIENT:
					cfg_ff.standby_init_edv_temp_cfg <= {1'b0, i_cfg_wdata[6:0]};
				gcc_pkg::ADDR_FILTER_SD: cfg_ff.filter_selfdischarge_cfg <= i_cfg_wdata;
				gcc_pkg::ADDR_AGING_TAPER: cfg_ff.aging_fullcharge_current_cfg <= i_cfg_wdata;
				gcc_pkg::ADDR_PACK_OPT: cfg_ff.pack_options_cfg <= i_cfg_wdata;
				gcc_pkg::ADDR_AGE_EDV: cfg_ff.age_gain_edv_rate_cfg <= i_cfg_wdata;
				default: cfg_ff <= cfg_ff;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_cfg_rdata <= 8'h00;
		end else begin
			case (i_cfg_addr)
				gcc_pkg::ADDR_STANDBY_EDV_TEMP_COEFFICIENT: o_cfg_rdata <= cfg_ff.standby_init_edv_temp_cfg;
				gcc_pkg::ADDR_FILTER_SD: o_cfg_rdata <= cfg_ff.filter_selfdischarge_cfg;
				gcc_pkg::ADDR_AGING_TAPER: o_cfg_rdata <= cfg_ff.aging_fullcharge_current_cfg;
				gcc_pkg::ADDR_PACK_OPT: o_cfg_rdata <= cfg_ff.pack_options_cfg;
				gcc_pkg::ADDR_AGE_EDV: o_cfg_rdata <= cfg_ff.age_gain_edv_rate_cfg;
				default: o_cfg_rdata <= 8'h00;
			endcase
		end
	end

	// pin enable: only reset and the mode register move it
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			gp_en_ff <= i_nv.pack_options_cfg[gcc_pkg::GP_EN_BIT];
		end else if (i_gp_en_wr) begin
			gp_en_ff <= i_gp_en_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_gp_o <= 1'b0;
			o_gp_oe <= 1'b0;
			o_gp_pin_input_enable <= 1'b0;
			o_gp_pin_status <= 1'b0;
		end else begin
			o_gp_o <= 1'b0;
			o_gp_oe <= 1'b0;
			o_gp_pin_input_enable <= gp_en_ff;
			o_gp_pin_status <= gp_en_ff ? i_gp_i : 1'b0;
		end
	end

	// standby current estimate
	logic si_tick;
	logic [25:0] ai_cuv;
	logic [25:0] dmf_cuv;
	logic [15:0] initial_standby_current_si;
	logic si_window;

	assign initial_standby_current_si = {9'h0, initial_standby_current, 4'h0};
	assign ai_cuv = 26'(i_meas.average_current * gcc_pkg::CUR_LSB_CUV);
	assign dmf_cuv = 26'(activity_filter_threshold * gcc_pkg::DMF_LSB_CUV);
	assign si_window = i_meas.discharging && (ai_cuv > dmf_cuv) &&
		({1'b0, i_meas.average_current} <= {initial_standby_current_si, 1'b0});

	gcc_interval_timer #(.W(48)) u_si_timer (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_en(1'b1),
		.i_step(48'h1),
		.i_limit(48'(SI_PERIOD_CYC)),
		.o_tick(si_tick)
	);

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			si_ff <= {9'h0, i_nv.standby_init_edv_temp_cfg[gcc_pkg::INITIAL_STANDBY_CURRENT_LSB +: 3], 4'h0};
		end else if (si_tick && si_window) begin
			si_ff <= 16'(si_ff - (si_ff >> 4) + (i_meas.average_current >> 4));
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_standby_current <= 16'h0;
			o_activity_filter_threshold <= 4'h0;
			o_learn_disqualified <= 1'b0;
		end else begin
			o_standby_current <= si_ff;
			o_activity_filter_threshold <= activity_filter_threshold;
			o_learn_disqualified <= {1'b0, i_meas.average_current} <= {initial_standby_current_si, 1'b0};
		end
	end

	// self-discharge band multiplier, in quarters
	logic [6:0] band_q;
	always_comb begin
		if (i_meas.temp_c >= 8'sd60) begin
			band_q = 7'd64;
		end else if (i_meas.temp_c >= 8'sd50) begin
			band_q = 7'd32;
		end else if (i_meas.temp_c >= 8'sd40) begin
			band_q = 7'd16;
		end else if (i_meas.temp_c >= 8'sd30) begin
			band_q = 7'd8;
		end else if (i_meas.temp_c >= 8'sd20) begin
			band_q = 7'd4;
		end else if (i_meas.temp_c >= 8'sd10) begin
			band_q = 7'd2;
		end else begin
			band_q = 7'd1;
		end
	end

	logic sd_tick;
	logic [47:0] sd_limit;
	assign sd_limit = 48'(self_discharge_rate * SD_UNIT_CYC * 4);

	gcc_interval_timer #(.W(48)) u_sd_timer (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_en(!i_meas.charging),
		.i_step({41'h0, band_q}),
		.i_limit(sd_limit),
		.o_tick(sd_tick)
	);

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_nac_reduce <= 1'b0;
			o_nac_reduce_amt <= 16'h0;
		end else begin
			o_nac_reduce <= sd_tick;
			o_nac_reduce_amt <= i_meas.nominal_available_capacity >> gcc_pkg::SD_FRACTION_SHIFT;
		end
	end

	// aging of full capacity
	logic sd_age_step;
	logic cyc_age_step;
	logic [15:0] age_unit;
	assign age_unit = i_meas.design_cap >> gcc_pkg::AGE_FRACTION_SHIFT;
	assign sd_age_step = sd_tick && (sd_cnt_ff == 3'(gcc_pkg::SD_PER_AGE_STEP - 4'd1));
	assign cyc_age_step = i_cycles_since_learning_inc && cycles_since_learning_odd_ff;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b || i_charged_full) begin
			sd_cnt_ff <= 3'h0;
		end else if (sd_tick) begin
			sd_cnt_ff <= sd_cnt_ff + 3'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cycles_since_learning_odd_ff <= 1'b0;
		end else if (i_cycles_since_learning_inc) begin
			cycles_since_learning_odd_ff <= !cycles_since_learning_odd_ff;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_lmd_reduce <= 1'b0;
			o_lmd_reduce_amt <= 16'h0;
		end else begin
			o_lmd_reduce <= aging_en && (sd_age_step || cyc_age_step);
			o_lmd_reduce_amt <= (sd_age_step && cyc_age_step) ? 16'(age_unit << 1) : age_unit;
		end
	end

	// charge termination
	logic [15:0] qv_mv;
	logic [6:0] taper;
	assign taper = cfg_ff.aging_fullcharge_current_cfg[6:0];
	always_comb begin
		case (cfg_ff.pack_options_cfg[gcc_pkg::QV_LSB +: 2])
			2'b00: qv_mv = gcc_pkg::QV_MV_0;
			2'b01: qv_mv = gcc_pkg::QV_MV_1;
			2'b10: qv_mv = gcc_pkg::QV_MV_2;
			2'b11: qv_mv = gcc_pkg::QV_MV_3;
			default: qv_mv = gcc_pkg::QV_MV_0;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_taper_threshold <= 7'h0;
			o_term_voltage_mv <= 16'h0;
			o_full_charge <= 1'b0;
		end else begin
			o_taper_threshold <= taper;
			o_term_voltage_mv <= qv_mv;
			o_full_charge <= i_meas.charging && (i_meas.volt_mv >= qv_mv) &&
				(ai_cuv < 26'(taper * gcc_pkg::TAPER_LSB_CUV));
		end
	end

	// offset and compensation bytes
	logic signed [7:0] board_offset;
	assign board_offset = 8'(signed'(cfg_ff.pack_options_cfg[gcc_pkg::BOARD_OFFSET_LSB +: 3]));

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_offset_total <= 8'sh0;
			o_eff_discharge_comp <= 8'h0;
			o_eff_temp_comp <= 8'h0;
		end else begin
			o_offset_total <= i_internal_offset + board_offset;
			o_eff_discharge_comp <= eff_discharge_comp_byte;
			o_eff_temp_comp <= eff_temp_comp_byte;
		end
	end

	// aged gain: discharge_gain * (1 + temperature_gain * cycles_total * gaf / 512)
	logic [41:0] age_term;
	assign age_term = discharge_gain * temperature_gain * i_meas.cycles_total * age_factor;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_aged_discharge_gain <= 24'h0;
		end else begin
			o_aged_discharge_gain <= 24'({19'h0, discharge_gain}
				+ (age_term >> gcc_pkg::AGE_GAIN_SHIFT));
		end
	end

	// first empty threshold compensation
	logic [39:0] edv_red_base;
	logic [39:0] edv_red;
	logic [15:0] edv_red_mv;
	logic [16:0] compensated_edv_raw;
	logic [15:0] compensated_edv;
	logic [16:0] floor_mv;

	assign edv_red_base = (i_meas.design_cap == 16'h0) ? 40'h0 :
		40'((gcc_pkg::EDV_MV_PER_COUNT * edv_rate_gain * i_meas.average_current)
		/ i_meas.design_cap);
	assign edv_red = edv_red_base + 40'((edv_red_base * edv_temp_coefficient * deficit)
		>> gcc_pkg::EDV_TEMP_COEFFICIENT_SHIFT);
	assign edv_red_mv = (edv_red > 40'h0FFFF) ? 16'hFFFF : edv_red[15:0];
	assign compensated_edv_raw = {1'b0, i_meas.first_empty_threshold} - {1'b0, edv_red_mv};
	assign compensated_edv = compensated_edv_raw[16] ? 16'h0 : compensated_edv_raw[15:0];
	assign floor_mv = {1'b0, i_meas.final_empty_threshold} + {1'b0, gcc_pkg::EDV_FLOOR_MARGIN_MV};

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_compensated_edv <= 16'h0;
			o_first_empty_eff <= 16'h0;
		end else if (i_meas.discharging) begin
			o_compensated_edv <= compensated_edv;
			o_first_empty_eff <= ({1'b0, compensated_edv} > floor_mv) ? compensated_edv : floor_mv[15:0];
		end
	end

	// checks
	sequence s_sd_step;
		sd_tick && aging_en && !i_charged_full;
	endsequence

	a_si_reset_load: assert property (@(posedge i_clk)
		!i_rst_b |=> o_standby_current == 16'h0 ##1
		si_ff == {9'h0, $past(i_nv.standby_init_edv_temp_cfg[6:4], 2), 4'h0})
		else $error("standby estimate not loaded at reset");

	a_si_window: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		si_tick && !si_window && i_rst_b |=> $stable(si_ff))
		else $error("standby estimate moved outside window");

	a_learn_disq: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		({1'b0, i_meas.average_current} <= {initial_standby_current_si, 1'b0}) |=> o_learn_disqualified)
		else $error("learning not disqualified");

	a_nac_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_nac_reduce |-> o_nac_reduce_amt == ($past(i_meas.nominal_available_capacity) >> 9))
		else $error("self-discharge amount wrong");

	a_band_cap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_meas.temp_c >= 8'sd60 |-> band_q == 7'd64) and (i_meas.temp_c < 8'sd10 |-> band_q == 7'd1))
		else $error("band multiplier out of range");

	a_no_aging: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!aging_en ##1 !$past(aging_en) |-> !o_lmd_reduce)
		else $error("capacity aged with aging disabled");

	a_age_after_eight: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		s_sd_step and (sd_cnt_ff == 3'h7) |=> o_lmd_reduce)
		else $error("eighth self-discharge step did not age capacity");

	a_gp_keep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_update_pack_config_cmd && !i_gp_en_wr |=> $stable(gp_en_ff))
		else $error("pack update moved pin enable");

	a_fixed_discharge_comp_byte: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		cfg_ff.pack_options_cfg[1] |=> o_eff_discharge_comp == 8'h6C)
		else $error("fixed discharge compensation not applied");

	a_fixed_temp_comp_byte: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		cfg_ff.pack_options_cfg[0] |=> o_eff_temp_comp == 8'h46)
		else $error("fixed temperature compensation not applied");

	a_edv_floor: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_meas.discharging |=> {1'b0, o_first_empty_eff} >= $past(floor_mv))
		else $error("first threshold below floor");
endmodule // gcc_config_comp

// [hw/gcc_interval_timer.sv]
// interval timer: accumulates a step each clock that i_en is high, pulses at a limit
// assumes limit of zero means disabled
`timescale 1ns/1ps
module gcc_interval_timer #(
	parameter int W = 48
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// control
	input wire logic i_en,
	input wire logic [W-1:0] i_step,
	input wire logic [W-1:0] i_limit,
	// event
	output logic o_tick
);
	logic [W-1:0] acc_ff;
	logic [W-1:0] nxt_acc;

	assign nxt_acc = acc_ff + i_step;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			acc_ff <= '0;
			o_tick <= 1'b0;
		end else if (i_en && (i_limit != '0)) begin
			o_tick <= (nxt_acc >= i_limit);
			acc_ff <= (nxt_acc >= i_limit) ? '0 : nxt_acc;
		end else begin
			o_tick <= 1'b0;
		end
	end
endmodule // gcc_interval_timer

// [hw/gcc_pkg.sv]
// package for the gauge configuration and compensation block
// assumes one 25 MHz clock and byte-wide configuration bytes
package gcc_pkg;
	localparam logic [7:0] ADDR_STANDBY_EDV_TEMP_COEFFICIENT = 8'h79;
	localparam logic [7:0] ADDR_FILTER_SD = 8'h7A;
	localparam logic [7:0] ADDR_AGING_TAPER = 8'h7B;
	localparam logic [7:0] ADDR_PACK_OPT = 8'h7C;
	localparam logic [7:0] ADDR_AGE_EDV = 8'h7D;
	// field positions
	localparam int INITIAL_STANDBY_CURRENT_LSB = 4;
	localparam int DMF_LSB = 4;
	localparam int AGING_EN_BIT = 7;
	localparam int GP_EN_BIT = 7;
	localparam int QV_LSB = 5;
	localparam int BOARD_OFFSET_LSB = 2;
	localparam int FIXED_DISCHARGE_COMP_BIT = 1;
	localparam int FIXED_TEMP_COMP_BIT = 0;
	localparam int GAF_LSB = 6;
	// fixed compensation bytes
	localparam logic [7:0] FIXED_DISCHARGE_COMP = 8'h6C;
	localparam logic [7:0] FIXED_TEMP_COMP = 8'h46;
	// charge termination voltages, mV
	localparam logic [15:0] QV_MV_0 = 16'd3968;
	localparam logic [15:0] QV_MV_1 = 16'd4016;
	localparam logic [15:0] QV_MV_2 = 16'd4064;
	localparam logic [15:0] QV_MV_3 = 16'd4112;
	// scales in 0.01 uV: current counts, filter steps, taper steps
	localparam logic [15:0] CUR_LSB_CUV = 16'd357;
	localparam logic [15:0] DMF_LSB_CUV = 16'd490;
	localparam logic [15:0] TAPER_LSB_CUV = 16'd22800;
	localparam int INITIAL_STANDBY_CURRENT_TO_SI_SHIFT = 4;
	localparam int SD_FRACTION_SHIFT = 9;
	localparam int AGE_FRACTION_SHIFT = 10;
	localparam logic [3:0] SD_PER_AGE_STEP = 4'd8;
	localparam logic [15:0] EDV_MV_PER_COUNT = 16'd8;
	localparam logic [15:0] EDV_FLOOR_MARGIN_MV = 16'd32;
	localparam int EDV_TEMP_COEFFICIENT_SHIFT = 7;
	localparam int AGE_GAIN_SHIFT = 9;
	// timing
	localparam longint CLK_HZ = 25000000;
	localparam longint SI_PERIOD_MS = 5120;
	localparam longint SI_PERIOD_CYC = SI_PERIOD_MS * (CLK_HZ / 1000);
	localparam longint SD_UNIT_S = 10485;
	localparam longint SD_UNIT_CYC = SD_UNIT_S * CLK_HZ;
	typedef struct packed {
		logic [7:0] standby_init_edv_temp_cfg;
		logic [7:0] filter_selfdischarge_cfg;
		logic [7:0] aging_fullcharge_current_cfg;
		logic [7:0] pack_options_cfg;
		logic [7:0] age_gain_edv_rate_cfg;
	} gcc_cfg_t;
	typedef struct packed {
		logic [15:0] average_current;
		logic discharging;
		logic charging;
		logic signed [7:0] temp_c;
		logic [15:0] volt_mv;
		logic [15:0] design_cap;
		logic [15:0] nominal_available_capacity;
		logic [15:0] first_empty_threshold;
		logic [15:0] final_empty_threshold;
		logic [15:0] cycles_total;
	} gcc_meas_t;
endpackage

// [test/testbench.sv]
// self-checking bench for the gauge configuration and compensation block
// assumes 25 MHz clock, shortened standby and self-discharge timing parameters
`timescale 1ns/1ps
module testbench;
	logic i_clk, i_rst_b, i_cfg_wr, i_update_pack_config_cmd, i_gp_en_wr, i_gp_en_wdata;
	logic i_charged_full, i_cycles_since_learning_inc, i_gp_i;
	logic [7:0] i_cfg_addr, i_cfg_wdata, i_discharge_comp_byte, i_temp_comp_byte;
	logic signed [7:0] i_internal_offset;
	gcc_pkg::gcc_cfg_t i_nv;
	gcc_pkg::gcc_meas_t i_meas;
	logic [7:0] o_cfg_rdata, o_eff_discharge_comp, o_eff_temp_comp;
	logic signed [7:0] o_offset_total;
	logic o_gp_o, o_gp_oe, o_gp_pin_input_enable, o_gp_pin_status, o_learn_disqualified;
	logic o_nac_reduce, o_lmd_reduce, o_full_charge;
	logic [15:0] o_standby_current, o_nac_reduce_amt, o_lmd_reduce_amt, o_term_voltage_mv;
	logic [15:0] o_compensated_edv, o_first_empty_eff;
	logic [3:0] o_activity_filter_threshold;
	logic [6:0] o_taper_threshold;
	logic [23:0] o_aged_discharge_gain;
	int n_errors = 0, checks = 0, cyc = 0, nac_cnt = 0, lmd_cnt = 0, seed = 30;
	logic [15:0] lmd_amt;
	string nm_q[$];
	logic [23:0] exp_q[$], obs_q[$];
	event noted;

	gcc_config_comp #(.SI_PERIOD_CYC(20), .SD_UNIT_CYC(64)) DUT (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_nv(i_nv), .i_cfg_wr(i_cfg_wr),
		.i_update_pack_config_cmd(i_update_pack_config_cmd), .i_cfg_addr(i_cfg_addr),
		.i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_gp_en_wr(i_gp_en_wr),
		.i_gp_en_wdata(i_gp_en_wdata), .i_discharge_comp_byte(i_discharge_comp_byte),
		.i_temp_comp_byte(i_temp_comp_byte), .i_meas(i_meas),
		.i_internal_offset(i_internal_offset), .i_charged_full(i_charged_full),
		.i_cycles_since_learning_inc(i_cycles_since_learning_inc), .i_gp_i(i_gp_i), .o_gp_o(o_gp_o), .o_gp_oe(o_gp_oe),
		.o_gp_pin_input_enable(o_gp_pin_input_enable), .o_gp_pin_status(o_gp_pin_status),
		.o_standby_current(o_standby_current),
		.o_activity_filter_threshold(o_activity_filter_threshold),
		.o_learn_disqualified(o_learn_disqualified), .o_nac_reduce(o_nac_reduce),
		.o_nac_reduce_amt(o_nac_reduce_amt), .o_lmd_reduce(o_lmd_reduce),
		.o_lmd_reduce_amt(o_lmd_reduce_amt), .o_taper_threshold(o_taper_threshold),
		.o_term_voltage_mv(o_term_voltage_mv), .o_full_charge(o_full_charge),
		.o_offset_total(o_offset_total), .o_eff_discharge_comp(o_eff_discharge_comp),
		.o_eff_temp_comp(o_eff_temp_comp), .o_aged_discharge_gain(o_aged_discharge_gain),
		.o_compensated_edv(o_compensated_edv), .o_first_empty_eff(o_first_empty_eff)
	);

	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// pulse counters and hang guard
	always @(posedge i_clk) begin
		cyc++;
		if (o_nac_reduce === 1'b1) nac_cnt++;
		if (o_lmd_reduce === 1'b1) begin
			lmd_cnt++;
			lmd_amt = o_lmd_reduce_amt;
		end
		if (cyc == 40000) begin
			n_errors++;
			final_report();
		end
	end

	// compares each observed result with the oldest expectation
	initial begin
		forever begin
			@(noted);
			while (obs_q.size() != 0) begin
				checks++;
				if (obs_q[0] !== exp_q[0]) begin
					n_errors++;
					$display("CHECK FAILED %s expected %0h seen %0h", nm_q[0], exp_q[0], obs_q[0]);
				end
				void'(nm_q.pop_front());
				void'(exp_q.pop_front());
				void'(obs_q.pop_front());
			end
		end
	end

	task automatic final_report();
		#1;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] o);
		nm_q.push_back(nm);
		exp_q.push_back(e);
		obs_q.push_back(o);
		-> noted;
	endtask

	task automatic cfg_write(input logic [7:0] a, input logic [7:0] d, input logic cmd);
		i_cfg_addr = a;
		i_cfg_wdata = d;
		if (cmd) i_update_pack_config_cmd = 1'b1;
		else i_cfg_wr = 1'b1;
		step(1);
		i_cfg_wr = 1'b0;
		i_update_pack_config_cmd = 1'b0;
		step(3);
	endtask

	task automatic cfg_read(input logic [7:0] a, input logic [7:0] e);
		i_cfg_addr = a;
		step(2);
		chk("cfg_rdata", {16'h0, e}, {16'h0, o_cfg_rdata});
	endtask

	// returns the cycle of the next self-discharge pulse
	task automatic wait_nac(output int t);
		int k;
		k = 0;
		while (o_nac_reduce !== 1'b1 && k < 3000) begin
			step(1);
			k++;
		end
		t = cyc;
		chk("nac_amt", 24'h000020, {8'h0, o_nac_reduce_amt});
		step(1);
	endtask

	task automatic pulse_cycles_since_learning();
		i_cycles_since_learning_inc = 1'b1;
		step(1);
		i_cycles_since_learning_inc = 1'b0;
		step(3);
	endtask

	int t0, t1, t2, n0, l0;
	logic [7:0] pk, b, dcb, tcb;
	logic signed [7:0] io;
	logic [15:0] qv_tab [4] = '{16'h0F80, 16'h0FB0, 16'h0FE0, 16'h1010};
	int temps [5] = '{25, 65, -5, 15, 45};
	int gaps [5] = '{128, 8, 512, 256, 32};

	initial begin
		i_rst_b = 1'b0;
		{i_cfg_wr, i_update_pack_config_cmd, i_gp_en_wr, i_gp_en_wdata} = 4'h0;
		{i_charged_full, i_cycles_since_learning_inc, i_gp_i} = 3'h0;
		i_cfg_addr = 8'h00;
		i_cfg_wdata = 8'h00;
		i_discharge_comp_byte = 8'h11;
		i_temp_comp_byte = 8'h22;
		i_internal_offset = 8'sh00;
		i_nv = '{8'h53, 8'h32, 8'hA0, 8'h80, 8'h40};
		i_meas = '{16'h0000, 1'b0, 1'b1, 8'sd25, 16'h0ED8, 16'h2800, 16'h4000,
			16'h0DAC, 16'h0D48, 16'h0000};
		repeat (6) @(posedge i_clk);
		#1;
		i_rst_b = 1'b1;
		step(3);
		chk("standby", 24'd80, {8'h0, o_standby_current});
		chk("pin_en", 24'h1, {23'h0, o_gp_pin_input_enable});
		chk("filter", 24'h3, {20'h0, o_activity_filter_threshold});
		chk("taper", 24'h20, {17'h0, o_taper_threshold});
		// pin as input, then mode write makes it undriven output
		i_gp_i = 1'b1;
		step(3);
		chk("pin_stat", 24'h1, {23'h0, o_gp_pin_status});
		i_gp_en_wr = 1'b1;
		i_gp_en_wdata = 1'b0;
		step(1);
		i_gp_en_wr = 1'b0;
		step(3);
		chk("pin_en_off", 24'h0, {21'h0, o_gp_pin_input_enable, o_gp_oe, o_gp_o});
		chk("pin_stat_off", 24'h0, {23'h0, o_gp_pin_status});
		// standby refinement inside and outside the qualifying window
		i_meas.discharging = 1'b1;
		i_meas.average_current = 16'd96;
		t0 = 0;
		while (o_standby_current === 16'd80 && t0 < 60) begin
			step(1);
			t0++;
		end
		i_meas.average_current = 16'd161;
		chk("standby_new", 24'd81, {8'h0, o_standby_current});
		step(60);
		chk("standby_high", 24'd81, {8'h0, o_standby_current});
		chk("disq_161", 24'h0, {23'h0, o_learn_disqualified});
		i_meas.average_current = 16'd4;
		step(60);
		chk("standby_low", 24'd81, {8'h0, o_standby_current});
		i_meas.discharging = 1'b0;
		i_meas.average_current = 16'd160;
		step(4);
		chk("disq_160", 24'h1, {23'h0, o_learn_disqualified});
		// first threshold compensation and floor
		i_meas.discharging = 1'b1;
		step(4);
		chk("compensated_edv", 24'h0DAC, {8'h0, o_compensated_edv});
		chk("edv_eff", 24'h0DAC, {8'h0, o_first_empty_eff});
		i_meas.final_empty_threshold = 16'h0D98;
		step(4);
		chk("edv_floor", 24'h0DB8, {8'h0, o_first_empty_eff});
		// rate and cold compensation of the first threshold, half C load
		i_meas.final_empty_threshold = 16'h0D48;
		i_meas.average_current = 16'd5120;
		cfg_write(8'h7D, 8'h48, 1'b0);
		cfg_write(8'h79, 8'h58, 1'b0);
		step(2);
		chk("compensated_edv_rate", 24'h0D8C, {8'h0, o_compensated_edv});
		i_meas.temp_c = -8'sd4;
		step(4);
		chk("compensated_edv_cold", 24'h0D7C, {8'h0, o_compensated_edv});
		chk("edv_eff_cold", 24'h0D7C, {8'h0, o_first_empty_eff});
		// aged gain and full charge detection
		i_meas.temp_c = 8'sd25;
		i_meas.cycles_total = 16'd64;
		i_meas.volt_mv = 16'd4000;
		step(2);
		chk("aged_gain", 24'd3, o_aged_discharge_gain);
		chk("full_hi_cur", 24'h0, {23'h0, o_full_charge});
		i_meas.average_current = 16'd160;
		step(2);
		chk("full_charge", 24'h1, {23'h0, o_full_charge});
		i_meas.discharging = 1'b0;
		// no self-discharge while charging, then aging by learning cycles
		n0 = nac_cnt;
		l0 = lmd_cnt;
		step(600);
		chk("nac_charging", 24'h0, 24'(nac_cnt - n0));
		pulse_cycles_since_learning();
		pulse_cycles_since_learning();
		chk("lmd_cycles_since_learning", 24'h1, 24'(lmd_cnt - l0));
		chk("lmd_amt", 24'd10, {8'h0, lmd_amt});
		// interval per temperature band
		i_meas.charging = 1'b0;
		for (int i = 0; i < 5; i++) begin
			i_meas.temp_c = 8'(temps[i]);
			wait_nac(t0);
			wait_nac(t1);
			wait_nac(t2);
			chk("sd_gap", 24'(gaps[i]), 24'(t2 - t1));
		end
		// eight self-discharge steps age full capacity
		i_meas.temp_c = 8'sd65;
		wait_nac(t0);
		i_charged_full = 1'b1;
		step(1);
		i_charged_full = 1'b0;
		n0 = nac_cnt;
		l0 = lmd_cnt;
		t0 = 0;
		while (lmd_cnt == l0 && t0 < 300) begin
			step(1);
			t0++;
		end
		chk("sd_per_age", 24'd8, 24'(nac_cnt - n0));
		chk("lmd_amt_sd", 24'd10, {8'h0, lmd_amt});
		// aging disabled: neither cause reduces full capacity
		cfg_write(8'h7B, 8'h20, 1'b0);
		l0 = lmd_cnt;
		step(200);
		pulse_cycles_since_learning();
		pulse_cycles_since_learning();
		chk("lmd_off", 24'h0, 24'(lmd_cnt - l0));
		i_meas.charging = 1'b1;
		// random pack options through the update command
		for (int i = 0; i < 12; i++) begin
			pk = 8'($random(seed));
			io = 8'($random(seed) % 32);
			dcb = 8'($random(seed));
			tcb = 8'($random(seed));
			b = 8'($random(seed));
			i_internal_offset = io;
			i_discharge_comp_byte = dcb;
			i_temp_comp_byte = tcb;
			cfg_write(8'h7C, pk, 1'b1);
			cfg_write(8'h7A, b, 1'b0);
			cfg_write(8'h7B, b, 1'b0);
			cfg_write(8'h79, b, 1'b0);
			cfg_read(8'h7C, pk);
			cfg_read(8'h79, {1'b0, b[6:0]});
			cfg_read(8'h6E, 8'h00);
			chk("pin_keep", 24'h0, {23'h0, o_gp_pin_input_enable});
			chk("term_mv", {8'h0, qv_tab[pk[6:5]]}, {8'h0, o_term_voltage_mv});
			chk("offset", {16'h0, 8'(io + {{5{pk[4]}}, pk[4:2]})}, {16'h0, o_offset_total});
			chk("discharge_comp_byte", {16'h0, pk[1] ? 8'h6C : dcb}, {16'h0, o_eff_discharge_comp});
			chk("temp_comp_byte", {16'h0, pk[0] ? 8'h46 : tcb}, {16'h0, o_eff_temp_comp});
			chk("filter_r", {20'h0, b[7:4]}, {20'h0, o_activity_filter_threshold});
			chk("taper_r", {17'h0, b[6:0]}, {17'h0, o_taper_threshold});
		end
		final_report();
	end
endmodule // testbench
